/* File: rtl/cadr_defines.svh */
// register offsets, field positions, reset values and timing counts
// assumes: included by the package and the register bank module
`ifndef CADR_DEFINES_SVH
`define CADR_DEFINES_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define CADR_OFS_AGC_CELL    8'h24
`define CADR_OFS_DRV_STAT    8'h25
`define CADR_OFS_IRQ_STAT    8'h30
`define CADR_OFS_IRQ_EN      8'h31
`define CADR_OFS_IRQ_CLR     8'h32

// ----------------------------------------------------------------
// cell agc register fields
// ----------------------------------------------------------------
`define CADR_AGC_NF_BIT      14
`define CADR_AGC_NL_HI       13
`define CADR_AGC_NL_LO       11
`define CADR_AGC_HYS_HI      10
`define CADR_AGC_HYS_LO      9
`define CADR_AGC_CLP_BIT     8
`define CADR_AGC_TG_HI       7
`define CADR_AGC_TG_LO       5
`define CADR_AGC_TC_HI       4
`define CADR_AGC_TC_LO       1
`define CADR_AGC_EN_BIT      0
`define CADR_AGC_WMASK       16'h3FFF
`define CADR_AGC_RESET       16'h0000

// ----------------------------------------------------------------
// driver status register fields
// ----------------------------------------------------------------
`define CADR_DRV_FL_HI       15
`define CADR_DRV_FL_LO       10
`define CADR_DRV_HEADPHONE_POP_REDUCE_OFF_BIT    9
`define CADR_DRV_BZ_BIT      8
`define CADR_DRV_SP2_BIT     7
`define CADR_DRV_SP1_BIT     6
`define CADR_DRV_DRIVER_POP_SEQUENCE_OFF_BIT    5
`define CADR_DRV_PST_BIT     4
`define CADR_DRV_WMASK       16'h03F0
`define CADR_DRV_FL_RESET    6'h3F
`define CADR_DRV_CTL_RESET   6'h00

// ----------------------------------------------------------------
// interrupt bits
// ----------------------------------------------------------------
`define CADR_IRQ_W           8
`define CADR_IRQ_NF          7
`define CADR_IRQ_SC          6

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CADR_CLK_MHZ         100
`define CADR_POP_SHORT_MS    802
`define CADR_POP_LONG_MS     4006
`define CADR_MS_CYCLES       (1000 * `CADR_CLK_MHZ)

`endif

/* File: rtl/cadr_pkg.sv */
// types shared by the register bank and its users
// assumes: the defines header is on the include path
package cadr_pkg;
	`include "cadr_defines.svh"

	// control fields of the cell agc register, for the gain loop
	typedef struct packed {
		logic [2:0] noise_threshold_level;
		logic [1:0] cell_hysteresis_select;
		logic       cell_clip_step_enable;
		logic [2:0] cell_target_level;
		logic [3:0] cell_time_constant;
		logic       cell_gain_loop_enable;
	} cadr_agc_cfg_t;

	// driver routing and pop controls
	typedef struct packed {
		logic headphone_pop_reduce_off;
		logic buzzer_route_off;
		logic speaker_two_buzzer_route;
		logic speaker_one_buzzer_route;
		logic driver_pop_sequence_off;
		logic pop_sequence_duration;
	} cadr_drv_cfg_t;

	// pop sequencer states
	typedef enum logic [2:0] {
		CADR_POP_IDLE = 3'b001,
		CADR_POP_RUN  = 3'b010,
		CADR_POP_DONE = 3'b100
	} cadr_pop_state_t;
endpackage

/* File: rtl/cadr_regs.sv */
// cell agc control and driver power-down status registers with interrupt
// assumes: one 100 MHz clock, status pins from analog are asynchronous
//
// Operation
// - bit 14 of the agc register reads 1 when signal is below noise threshold.
// - noise flag means something only while the cell agc is enabled.
// - three-bit noise threshold shared by all agc; codes 0,1 give -30 dB.
// - hysteresis code selects 1, 2, 4 dB or none.
// - bit 8 enables clip stepping for the cell agc.
// - three-bit target field selects output level from -5.5 to -24 dB.
// - time-constant field picks attack and decay, fixed regardless of sample rate.
// - bit 0 turns the cell agc on.
// - driver status valid only while short-circuit detect reads 0.
// - bits 15..10 report six drivers powered down, reset to 1.
// - bit 9 low enables headphone pop reduction.
// - bit 8 low enables routing into the buzzer gain stage.
// - bits 7 and 6 enable speaker two and one into buzzer stage.
// - bit 5 low enables pop sequencing of four drivers.
// - bit 4 picks pop sequencing time 802 ms or 4006 ms.
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ns
`include "cadr_defines.svh"

module cadr_regs
	import cadr_pkg::*;
#(
	parameter int unsigned POP_SHORT_CYC = `CADR_POP_SHORT_MS * `CADR_MS_CYCLES,
	parameter int unsigned POP_LONG_CYC  = `CADR_POP_LONG_MS * `CADR_MS_CYCLES
) (
	input  wire logic        clk_i,
	input  wire logic        arst_n_i,
	input  wire logic [7:0]  addr_i,
	input  wire logic [15:0] wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic      [15:0] rdata_o,
	input  wire logic        noise_below_i,
	input  wire logic [5:0]  driver_down_i,
	input  wire logic        short_detect_i,
	output cadr_agc_cfg_t    agc_cfg_o,
	output cadr_drv_cfg_t    drv_cfg_o,
	output logic             pop_active_o,
	output logic             irq_o
);

	// ----------------------------------------------------------------
	// input synchronisers
	// ----------------------------------------------------------------
	logic [7:0] sync1_reg;
	logic [7:0] sync2_reg;

	// two flops on every analog status pin, reset to idle levels so no false edge follows reset
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sync1_reg <= 8'h3F;
			sync2_reg <= 8'h3F;
		end else begin
			sync1_reg <= {short_detect_i, noise_below_i, driver_down_i};
			sync2_reg <= sync1_reg;
		end
	end

	logic       short_s;
	logic       noise_s;
	logic [5:0] down_s;
	assign short_s = sync2_reg[7];
	assign noise_s = sync2_reg[6];
	assign down_s  = sync2_reg[5:0];

	// ----------------------------------------------------------------
	// address decode
	// ----------------------------------------------------------------
	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		hit = (a == ofs);
	endfunction

	logic wr_agc;
	logic wr_drv;
	logic wr_en;
	logic wr_clr;
	assign wr_agc = wr_i && hit(addr_i, `CADR_OFS_AGC_CELL);
	assign wr_drv = wr_i && hit(addr_i, `CADR_OFS_DRV_STAT);
	assign wr_en  = wr_i && hit(addr_i, `CADR_OFS_IRQ_EN);
	assign wr_clr = wr_i && hit(addr_i, `CADR_OFS_IRQ_CLR);

	// ----------------------------------------------------------------
	// cell agc register
	// ----------------------------------------------------------------
	logic [13:0] agc_reg;

	// only bits 13..0 are stored; flag and reserved bit ignore writes
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			agc_reg <= 14'h0000;
		end else if (wr_agc) begin
			agc_reg <= wdata_i[13:0];
		end
	end

	assign agc_cfg_o = cadr_agc_cfg_t'(agc_reg);

	// noise flag read value, held low while the loop is off
	logic noise_flag;
	assign noise_flag = noise_s & agc_reg[`CADR_AGC_EN_BIT];

	// ----------------------------------------------------------------
	// driver status register
	// ----------------------------------------------------------------
	logic [5:0] drv_ctl_reg;
	logic [5:0] drv_fl_reg;

	// writable routing and pop bits
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			drv_ctl_reg <= `CADR_DRV_CTL_RESET;
		end else if (wr_drv) begin
			drv_ctl_reg <= wdata_i[9:4];
		end
	end

	// power-down flags frozen while a short is detected
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			drv_fl_reg <= `CADR_DRV_FL_RESET;
		end else if (!short_s) begin
			drv_fl_reg <= down_s;
		end
	end

	assign drv_cfg_o = cadr_drv_cfg_t'(drv_ctl_reg);

	// ----------------------------------------------------------------
	// pop sequencer timer
	// ----------------------------------------------------------------
	cadr_pop_state_t pop_state_reg;
	logic [31:0]     pop_cnt_reg;
	logic            pop_start;
	// a write that enables sequencing starts a run when the sequencer is idle
	assign pop_start = wr_drv && !wdata_i[`CADR_DRV_DRIVER_POP_SEQUENCE_OFF_BIT];

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pop_state_reg <= CADR_POP_IDLE;
			pop_cnt_reg   <= 32'h0000_0000;
		end else begin
			case (pop_state_reg)
				CADR_POP_IDLE: begin
					if (pop_start) begin
						pop_state_reg <= CADR_POP_RUN;
						pop_cnt_reg   <= wdata_i[`CADR_DRV_PST_BIT] ? POP_LONG_CYC - 1 : POP_SHORT_CYC - 1;
					end
				end
				CADR_POP_RUN: begin
					if (drv_ctl_reg[1]) begin
						pop_state_reg <= CADR_POP_IDLE;
					end else if (pop_cnt_reg == 32'h0000_0000) begin
						pop_state_reg <= CADR_POP_DONE;
					end else begin
						pop_cnt_reg <= pop_cnt_reg - 32'h0000_0001;
					end
				end
				CADR_POP_DONE: begin
					pop_state_reg <= CADR_POP_IDLE;
				end
				default: begin
					pop_state_reg <= CADR_POP_IDLE;
				end
			endcase
		end
	end

	assign pop_active_o = (pop_state_reg == CADR_POP_RUN);

	// ----------------------------------------------------------------
	// interrupts
	// ----------------------------------------------------------------
	logic [7:0] irq_stat_reg;
	logic [7:0] irq_en_reg;
	logic [7:0] irq_ev;
	logic       nf_d_reg;
	logic       sc_d_reg;
	logic [5:0] fl_d_reg;

	// edge detectors on synchronised levels
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			nf_d_reg <= 1'b0;
			sc_d_reg <= 1'b0;
			fl_d_reg <= `CADR_DRV_FL_RESET;
		end else begin
			nf_d_reg <= noise_flag;
			sc_d_reg <= short_s;
			fl_d_reg <= drv_fl_reg;
		end
	end

	assign irq_ev = {noise_flag & ~nf_d_reg, short_s & ~sc_d_reg, drv_fl_reg ^ fl_d_reg};

	// sticky status; a new event beats a clear in the same cycle
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			irq_stat_reg <= 8'h00;
		end else begin
			irq_stat_reg <= (irq_stat_reg & ~(wr_clr ? wdata_i[7:0] : 8'h00)) | irq_ev;
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			irq_en_reg <= 8'h00;
		end else if (wr_en) begin
			irq_en_reg <= wdata_i[7:0];
		end
	end

	assign irq_o = |(irq_stat_reg & irq_en_reg);

	// ----------------------------------------------------------------
	// read data, one cycle after the strobe
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rdata_o <= 16'h0000;
		end else if (rd_i) begin
			if (hit(addr_i, `CADR_OFS_AGC_CELL)) begin
				rdata_o <= {1'b0, noise_flag, agc_reg};
			end else if (hit(addr_i, `CADR_OFS_DRV_STAT)) begin
				rdata_o <= {drv_fl_reg, drv_ctl_reg, 4'h0};
			end else if (hit(addr_i, `CADR_OFS_IRQ_STAT)) begin
				rdata_o <= {8'h00, irq_stat_reg};
			end else if (hit(addr_i, `CADR_OFS_IRQ_EN)) begin
				rdata_o <= {8'h00, irq_en_reg};
			end else begin
				rdata_o <= 16'h0000;
			end
		end else begin
			rdata_o <= 16'h0000;
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	sequence s_agc_write;
		wr_agc;
	endsequence

	property p_agc_hold;
		@(posedge clk_i) disable iff (!arst_n_i)
		!wr_agc |=> $stable(agc_cfg_o);
	endproperty
	a_agc_hold: assert property (p_agc_hold) else $error("agc field changed without write");

	property p_flag_off;
		@(posedge clk_i) disable iff (!arst_n_i)
		rd_i && hit(addr_i, `CADR_OFS_AGC_CELL) && !agc_reg[0] |=> rdata_o[15:14] == 2'b00;
	endproperty
	a_flag_off: assert property (p_flag_off) else $error("noise flag set while loop off");

	property p_flag_read;
		@(posedge clk_i) disable iff (!arst_n_i)
		rd_i && hit(addr_i, `CADR_OFS_AGC_CELL) |=> rdata_o[14] == $past(noise_flag);
	endproperty
	a_flag_read: assert property (p_flag_read) else $error("noise flag read wrong");

	property p_drv_rsvd;
		@(posedge clk_i) disable iff (!arst_n_i)
		rd_i && hit(addr_i, `CADR_OFS_DRV_STAT) |=> rdata_o[3:0] == 4'h0 && rdata_o[15:10] == $past(drv_fl_reg);
	endproperty
	a_drv_rsvd: assert property (p_drv_rsvd) else $error("driver status read wrong");

	property p_short_freeze;
		@(posedge clk_i) disable iff (!arst_n_i)
		short_s |=> drv_fl_reg == $past(drv_fl_reg);
	endproperty
	a_short_freeze: assert property (p_short_freeze) else $error("flags moved during short");

	property p_drv_write;
		@(posedge clk_i) disable iff (!arst_n_i)
		wr_drv |=> drv_cfg_o == cadr_drv_cfg_t'($past(wdata_i[9:4]));
	endproperty
	a_drv_write: assert property (p_drv_write) else $error("driver controls not stored");

	property p_pop_start;
		@(posedge clk_i) disable iff (!arst_n_i)
		pop_state_reg == CADR_POP_IDLE && pop_start |=> pop_active_o ##1 pop_active_o || drv_ctl_reg[1];
	endproperty
	a_pop_start: assert property (p_pop_start) else $error("pop run did not start");

	property p_pop_len;
		@(posedge clk_i) disable iff (!arst_n_i)
		pop_state_reg == CADR_POP_IDLE && pop_start && wdata_i[4] |=> pop_cnt_reg == POP_LONG_CYC - 1;
	endproperty
	a_pop_len: assert property (p_pop_len) else $error("long pop count wrong");

	property p_irq_sticky;
		@(posedge clk_i) disable iff (!arst_n_i)
		irq_ev[7] |=> irq_stat_reg[7];
	endproperty
	a_irq_sticky: assert property (p_irq_sticky) else $error("event lost against clear");

	property p_agc_write;
		@(posedge clk_i) disable iff (!arst_n_i)
		s_agc_write |=> agc_cfg_o == cadr_agc_cfg_t'($past(wdata_i[13:0]));
	endproperty
	a_agc_write: assert property (p_agc_write) else $error("agc fields not stored");

	property p_agc_read;
		@(posedge clk_i) disable iff (!arst_n_i)
		rd_i && hit(addr_i, `CADR_OFS_AGC_CELL) |=> !rdata_o[15] && rdata_o[13:0] == $past(agc_reg);
	endproperty
	a_agc_read: assert property (p_agc_read) else $error("agc register read wrong");

	property p_drv_hold;
		@(posedge clk_i) disable iff (!arst_n_i)
		!wr_drv |=> $stable(drv_cfg_o);
	endproperty
	a_drv_hold: assert property (p_drv_hold) else $error("driver controls changed without write");

	property p_rd_idle;
		@(posedge clk_i) disable iff (!arst_n_i)
		!rd_i |=> rdata_o == 16'h0000;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data not zero outside read");

	property p_fl_track;
		@(posedge clk_i) disable iff (!arst_n_i)
		!short_s |=> drv_fl_reg == $past(down_s);
	endproperty
	a_fl_track: assert property (p_fl_track) else $error("driver flags not following inputs");

	property p_irq_clear;
		@(posedge clk_i) disable iff (!arst_n_i)
		wr_clr && irq_ev == 8'h00 |=> (irq_stat_reg & $past(wdata_i[7:0])) == 8'h00;
	endproperty
	a_irq_clear: assert property (p_irq_clear) else $error("status bit not cleared");

	property p_fl_event;
		@(posedge clk_i) disable iff (!arst_n_i)
		irq_ev[5:0] != 6'h00 |=> (irq_stat_reg[5:0] & $past(irq_ev[5:0])) == $past(irq_ev[5:0]);
	endproperty
	a_fl_event: assert property (p_fl_event) else $error("driver flag change not latched");

	property p_sc_event;
		@(posedge clk_i) disable iff (!arst_n_i)
		irq_ev[6] |=> irq_stat_reg[6];
	endproperty
	a_sc_event: assert property (p_sc_event) else $error("short detect event not latched");

	property p_pop_abort;
		@(posedge clk_i) disable iff (!arst_n_i)
		pop_active_o && drv_ctl_reg[1] |=> !pop_active_o;
	endproperty
	a_pop_abort: assert property (p_pop_abort) else $error("pop run not aborted");

	property p_pop_short;
		@(posedge clk_i) disable iff (!arst_n_i)
		pop_state_reg == CADR_POP_IDLE && pop_start && !wdata_i[4] |=> pop_cnt_reg == POP_SHORT_CYC - 1;
	endproperty
	a_pop_short: assert property (p_pop_short) else $error("short pop count wrong");

	property p_pop_count;
		@(posedge clk_i) disable iff (!arst_n_i)
		pop_active_o && !drv_ctl_reg[1] && pop_cnt_reg != 32'h0000_0000 |=> pop_cnt_reg == $past(pop_cnt_reg) - 1;
	endproperty
	a_pop_count: assert property (p_pop_count) else $error("pop counter not stepping");

	sequence s_pop_finish;
		pop_state_reg == CADR_POP_DONE ##1 pop_state_reg == CADR_POP_IDLE;
	endsequence

	property p_pop_end;
		@(posedge clk_i) disable iff (!arst_n_i)
		pop_active_o && !drv_ctl_reg[1] && pop_cnt_reg == 32'h0000_0000 |=> s_pop_finish;
	endproperty
	a_pop_end: assert property (p_pop_end) else $error("pop run did not finish");

endmodule // cadr_regs

/* File: tb/cadr_regs_tb_top.sv */
// self-checking bench for the cell agc and driver status register bank
// assumes: pop timer parameters shortened to 20 and 50 cycles
`timescale 1ns/1ns
`include "cadr_defines.svh"

module cadr_regs_tb_top
	import cadr_pkg::*;
;
	localparam int PS = 20;
	localparam int PL = 50;
	logic          clk_i;
	logic          arst_n_i;
	logic [7:0]    addr_i;
	logic [15:0]   wdata_i;
	logic          wr_i;
	logic          rd_i;
	logic [15:0]   rdata_o;
	logic          noise_below_i;
	logic [5:0]    driver_down_i;
	logic          short_detect_i;
	cadr_agc_cfg_t agc_cfg_o;
	cadr_drv_cfg_t drv_cfg_o;
	logic          pop_active_o;
	logic          irq_o;
	int            errors;
	int            cmp_count;
	logic [15:0]   v;
	int            n;

	cadr_regs #(.POP_SHORT_CYC(PS), .POP_LONG_CYC(PL)) cadr_regs_i (
		.clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .noise_below_i(noise_below_i),
		.driver_down_i(driver_down_i), .short_detect_i(short_detect_i),
		.agc_cfg_o(agc_cfg_o), .drv_cfg_o(drv_cfg_o), .pop_active_o(pop_active_o), .irq_o(irq_o)
	);

	// ----------------------------------------------------------------
	// clock, tasks
	// ----------------------------------------------------------------
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	// compare one value and count it
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// one-cycle write strobe
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask

	// one-cycle read strobe, data taken in the following cycle
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge clk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge clk_i);
		rd_i <= 1'b0;
		@(posedge clk_i);
		d = rdata_o;
	endtask

	// let synchronisers settle
	task automatic idle(input int c);
		repeat (c) @(posedge clk_i);
	endtask

	// measure one pop run length in cycles
	task automatic pop_len(input int exp);
		n = 0;
		while (pop_active_o !== 1'b1 && n < 5) begin
			idle(1);
			n++;
		end
		n = 0;
		while (pop_active_o === 1'b1 && n < 200) begin
			idle(1);
			n++;
		end
		chk({15'h0, (n >= exp - 2 && n <= exp + 2)}, 16'h1);
	endtask

	task automatic stop_test;
		$display("compares=%0d mismatches=%0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// watchdog
	// ----------------------------------------------------------------
	initial begin
		repeat (20000) @(posedge clk_i);
		errors++;
		stop_test;
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		errors = 0;
		cmp_count = 0;
		arst_n_i = 1'b0;
		addr_i = 8'h00;
		wdata_i = 16'h0000;
		wr_i = 1'b0;
		rd_i = 1'b0;
		noise_below_i = 1'b0;
		driver_down_i = 6'h3F;
		short_detect_i = 1'b0;
		repeat (2) @(posedge clk_i);
		arst_n_i <= 1'b1;
		// reset values
		rd(`CADR_OFS_AGC_CELL, v);
		chk(v, 16'h0000);
		rd(`CADR_OFS_DRV_STAT, v);
		chk(v, 16'hFC00);
		$display("test reset done");
		// agc fields hold written codes, reserved and flag bits stay 0
		for (int i = 0; i < 8; i++) begin
			v = {2'b01, i[2:0], i[1:0], i[0], ~i[2:0], i[2:0], ~i[0], i[0] & ~i[2]};
			wr(`CADR_OFS_AGC_CELL, v);
			idle(1);
			chk({2'b00, agc_cfg_o}, v & 16'h3FFF);
			rd(`CADR_OFS_AGC_CELL, v);
			chk(v[15:14], 2'b00);
		end
		$display("test agc fields done");
		// noise flag follows the input only with the loop on
		wr(`CADR_OFS_AGC_CELL, 16'h0001);
		noise_below_i <= 1'b1;
		idle(4);
		rd(`CADR_OFS_AGC_CELL, v);
		chk(v, 16'h4001);
		wr(`CADR_OFS_AGC_CELL, 16'h0000);
		rd(`CADR_OFS_AGC_CELL, v);
		chk(v, 16'h0000);
		noise_below_i <= 1'b0;
		wr(`CADR_OFS_AGC_CELL, 16'h0001);
		idle(4);
		rd(`CADR_OFS_AGC_CELL, v);
		chk(v, 16'h0001);
		$display("test noise flag done");
		// each driver control bit with bit 5 also set, flag bits written as ones and read back
		for (int b = 0; b < 6; b++) begin
			wr(`CADR_OFS_DRV_STAT, (16'h0010 << b) | 16'h0020 | 16'hFC00);
			idle(1);
			chk({10'h0, drv_cfg_o}, (16'h0001 << b) | 16'h0002);
			rd(`CADR_OFS_DRV_STAT, v);
			chk(v, 16'hFC00 | (16'h0010 << b) | 16'h0020);
		end
		$display("test driver controls done");
		// pop runs short, long, and abort
		wr(`CADR_OFS_DRV_STAT, 16'h0000);
		pop_len(PS);
		wr(`CADR_OFS_DRV_STAT, 16'h0010);
		pop_len(PL);
		wr(`CADR_OFS_DRV_STAT, 16'h0010);
		idle(5);
		wr(`CADR_OFS_DRV_STAT, 16'h0030);
		idle(2);
		chk({15'h0, pop_active_o}, 16'h0000);
		$display("test pop sequencing done");
		// interrupt: raise, mask, clear, read-only status
		wr(`CADR_OFS_IRQ_EN, 16'h00FF);
		wr(`CADR_OFS_IRQ_CLR, 16'h00FF);
		rd(`CADR_OFS_IRQ_EN, v);
		chk(v, 16'h00FF);
		chk({15'h0, irq_o}, 16'h0000);
		driver_down_i <= 6'h3E;
		idle(4);
		rd(`CADR_OFS_IRQ_STAT, v);
		chk(v, 16'h0001);
		chk({15'h0, irq_o}, 16'h0001);
		wr(`CADR_OFS_IRQ_EN, 16'h0000);
		idle(1);
		chk({15'h0, irq_o}, 16'h0000);
		wr(`CADR_OFS_IRQ_STAT, 16'h0000);
		rd(`CADR_OFS_IRQ_STAT, v);
		chk(v, 16'h0001);
		wr(`CADR_OFS_IRQ_EN, 16'h00FF);
		wr(`CADR_OFS_IRQ_CLR, 16'h00FF);
		idle(1);
		chk({15'h0, irq_o}, 16'h0000);
		// flags freeze while a short is detected
		short_detect_i <= 1'b1;
		idle(4);
		driver_down_i <= 6'h00;
		idle(4);
		rd(`CADR_OFS_DRV_STAT, v);
		chk(v & 16'hFC00, 16'hF800);
		rd(`CADR_OFS_IRQ_STAT, v);
		chk(v, 16'h0040);
		wr(`CADR_OFS_IRQ_CLR, 16'h00FF);
		short_detect_i <= 1'b0;
		idle(4);
		rd(`CADR_OFS_DRV_STAT, v);
		chk(v & 16'hFC00, 16'h0000);
		rd(`CADR_OFS_IRQ_STAT, v);
		chk(v, 16'h003E);
		wr(`CADR_OFS_IRQ_CLR, 16'h00FF);
		noise_below_i <= 1'b1;
		idle(4);
		rd(`CADR_OFS_IRQ_STAT, v);
		chk(v, 16'h0080);
		rd(8'h40, v);
		chk(v, 16'h0000);
		$display("test interrupt done");
		stop_test;
	end
endmodule // cadr_regs_tb_top
